/* File: serdes_pkg.sv */
`default_nettype none
package serdes_pkg;
  // protocol codes held in the low nibble of the mode register
  localparam logic [3:0] PROTO_ETH = 4'h1;
  localparam logic [3:0] PROTO_USB = 4'h2;
  localparam logic [3:0] PROTO_UART = 4'h3;
  localparam logic [3:0] PROTO_SPI = 4'h5;
  localparam logic [3:0] PROTO_GPSI = 4'h6;

  // register byte addresses, one aligned word each
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_SYNC = 8'h04;
  localparam logic [7:0] OFS_RX_SHIFT = 8'h08;
  localparam logic [7:0] OFS_RX_RCVD = 8'h0C;
  localparam logic [7:0] OFS_TX_COUNT = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;
  localparam logic [7:0] OFS_RX_BUF = 8'h1C;
  localparam logic [7:0] OFS_TX_BUF_LO = 8'h20;
  localparam logic [7:0] OFS_TX_BUF_HI = 8'h24;
  localparam logic [7:0] OFS_CLK_DIV = 8'h28;

  // field layout
  localparam int MODE_W = 5;
  localparam int MODE_EXT_CLK = 4;
  localparam int CNT_W = 5;
  localparam int FLAG_W = 4;
  localparam int FLAG_RX_FULL = 0;
  localparam int FLAG_TX_EMPTY = 1;
  localparam int FLAG_TX_UNDERRUN = 2;
  localparam int FLAG_RX_EOP = 3;

  // reset values
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h10;
  localparam logic [15:0] DIV_RST = 16'h0007;

  // fixed start-of-frame pattern in 10Base-T
  localparam logic [7:0] SFD_ETH = 8'hD5;
  // length of the generated end-of-packet, in bit times
  localparam logic [1:0] EOP_BITS = 2'h2;
  // usb inserts a stuff bit after this many ones
  localparam logic [2:0] STUFF_ONES = 3'h6;

  // pre-emphasis delay, least time so rounded up
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PE_DELAY_NS = 50;
  localparam int PE_CYCLES = (PE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  function automatic logic is_diff(input logic [3:0] code);
    return (code == PROTO_ETH) || (code == PROTO_USB);
  endfunction

  function automatic logic rx_eop_mode(input logic [3:0] code);
    return (code == PROTO_ETH) || (code == PROTO_USB) || (code == PROTO_GPSI);
  endfunction
endpackage
`default_nettype wire

/* File: multiprotocol_serdes.sv */
`timescale 1ns/1ps
`default_nettype none
module multiprotocol_serdes (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] avs_address_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic serial_clock_pin_in,
  input wire logic rx_plus_pin_in,
  input wire logic rx_minus_pin_in,
  input wire logic rx_data_pin_in,
  output logic tx_plus_pin_out,
  output logic tx_minus_pin_out,
  output logic tx_plus_delayed_pin_out,
  output logic tx_minus_delayed_pin_out,
  output logic irq_out
);
  import serdes_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_EOP} tx_state_t;
  typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_DATA} rx_state_t;

  // merge write data into an old word under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // every register below belongs to this unit alone, so two instances run apart
  logic [MODE_W-1:0] mode_r;
  logic [7:0] sync_r;
  logic [CNT_W-1:0] rx_cfg_r;
  logic [CNT_W-1:0] rx_rcvd_r;
  logic [CNT_W-1:0] tx_cfg_r;
  logic [FLAG_W-1:0] ien_r;
  logic [FLAG_W-1:0] flag_r;
  logic [FLAG_W-1:0] flag_nxt;
  logic [15:0] rbuf_r;
  logic [15:0] tbuf_r;
  logic [15:0] div_r;
  logic tbuf_lo_r;
  logic tbuf_hi_r;
  logic tbuf_full_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;

  logic [3:0] code;
  logic acc;
  logic wr_acc;
  logic rx_setup;
  logic [31:0] rd_mux;
  logic [31:0] wr_word;
  logic [31:0] wr_merged;

  assign code = mode_r[3:0];
  assign acc = (avs_read_in | avs_write_in) & ~wait_r;
  assign wr_acc = acc & avs_write_in;
  assign rx_setup = wr_acc && (avs_address_in == OFS_RX_SHIFT);

  // read mux; narrow registers sit low and unmapped words read as zero
  always_comb begin
    wr_word = be_merge(32'h0000_0000, avs_writedata_in, avs_byteenable_in);
    rd_mux = 32'h0000_0000;
    unique case (avs_address_in)
      OFS_MODE: rd_mux[MODE_W-1:0] = mode_r;
      OFS_SYNC: rd_mux[7:0] = sync_r;
      OFS_RX_SHIFT: rd_mux[CNT_W-1:0] = rx_cfg_r;
      OFS_RX_RCVD: rd_mux[CNT_W-1:0] = rx_rcvd_r;
      OFS_TX_COUNT: rd_mux[CNT_W-1:0] = tx_cfg_r;
      OFS_IRQ_EN: rd_mux[FLAG_W-1:0] = ien_r;
      OFS_IRQ_FLAG: rd_mux[FLAG_W-1:0] = flag_r;
      OFS_RX_BUF: rd_mux[15:0] = rbuf_r;
      OFS_CLK_DIV: rd_mux[15:0] = div_r;
      default: rd_mux = 32'h0000_0000;
    endcase
    // disabled byte lanes keep what the addressed register holds now
    wr_merged = be_merge(rd_mux, avs_writedata_in, avs_byteenable_in);
  end

  // one wait cycle per access: it gives the read mux a full cycle to settle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (acc) begin
      wait_r <= 1'b1;
    end else if (avs_read_in | avs_write_in) begin
      wait_r <= 1'b0;
      rdata_r <= rd_mux;
    end
  end

  // configuration registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_r <= MODE_RST;
      sync_r <= SYNC_RST;
      rx_cfg_r <= CNT_RST;
      tx_cfg_r <= CNT_RST;
      ien_r <= '0;
      div_r <= DIV_RST;
    end else if (wr_acc) begin
      unique case (avs_address_in)
        OFS_MODE: mode_r <= wr_merged[MODE_W-1:0];
        OFS_SYNC: sync_r <= wr_merged[7:0];
        OFS_RX_SHIFT: rx_cfg_r <= wr_merged[CNT_W-1:0];
        OFS_TX_COUNT: tx_cfg_r <= wr_merged[CNT_W-1:0];
        OFS_IRQ_EN: ien_r <= wr_merged[FLAG_W-1:0];
        OFS_CLK_DIV: div_r <= wr_merged[15:0];
        default: ;
      endcase
    end
  end

  // bit timing: internal divider gives half-bit ticks, or the pin clocks whole bits
  logic [15:0] div_cnt_r;
  logic phase_r;
  logic sclk_prev_r;
  logic ext_clk;
  logic sclk_edge;
  logic half_tick;
  logic full_tick;

  assign ext_clk = (code == PROTO_SPI) || (code == PROTO_GPSI) ||
                   (mode_r[MODE_EXT_CLK] && ((code == PROTO_USB) || (code == PROTO_UART)));
  assign sclk_edge = serial_clock_pin_in & ~sclk_prev_r;
  assign half_tick = ext_clk ? sclk_edge : (div_cnt_r == 16'h0000);
  assign full_tick = ext_clk ? sclk_edge : (half_tick & phase_r);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt_r <= 16'h0000;
      phase_r <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= serial_clock_pin_in;
      div_cnt_r <= (div_cnt_r == 16'h0000) ? div_r : div_cnt_r - 16'h0001;
      if (half_tick) begin
        phase_r <= ~phase_r;
      end
    end
  end

  // transmit buffer: a word counts as loaded only once both bytes were written
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tbuf_r <= 16'h0000;
      tbuf_lo_r <= 1'b0;
      tbuf_hi_r <= 1'b0;
    end else if (wr_acc && avs_byteenable_in[0]) begin
      if (avs_address_in == OFS_TX_BUF_LO) begin
        tbuf_r[7:0] <= avs_writedata_in[7:0];
        tbuf_lo_r <= 1'b1;
      end else if (avs_address_in == OFS_TX_BUF_HI) begin
        tbuf_r[15:8] <= avs_writedata_in[7:0];
        tbuf_hi_r <= 1'b1;
      end
    end else if (tbuf_lo_r & tbuf_hi_r) begin
      tbuf_lo_r <= 1'b0;
      tbuf_hi_r <= 1'b0;
    end
  end

  // transmitter
  tx_state_t tx_state_r;
  logic [15:0] tx_sh_r;
  logic [CNT_W-1:0] tx_left_r;
  logic [1:0] eop_cnt_r;
  logic tx_level_r;
  logic [2:0] tx_ones_r;
  logic tx_stuff_r;
  logic tx_done;
  logic stuff_now;
  logic tx_load;
  logic tx_underrun;

  assign tx_done = (tx_left_r <= 5'h01);
  assign stuff_now = (code == PROTO_USB) && (tx_ones_r == STUFF_ONES) && !tx_stuff_r;
  assign tx_load = full_tick && tbuf_full_r &&
                   ((tx_state_r == TX_IDLE) || ((tx_state_r == TX_SHIFT) && tx_done && !stuff_now));
  assign tx_underrun = full_tick && (tx_state_r == TX_SHIFT) && tx_done && !stuff_now &&
                       !tbuf_full_r;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tbuf_full_r <= 1'b0;
    end else begin
      tbuf_full_r <= (tbuf_full_r & ~tx_load) | (tbuf_lo_r & tbuf_hi_r);
    end
  end

  // shift engine; nrzi level is worked out as each new bit becomes current
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state_r <= TX_IDLE;
      tx_sh_r <= 16'h0000;
      tx_left_r <= '0;
      eop_cnt_r <= 2'h0;
      tx_level_r <= 1'b0;
      tx_ones_r <= 3'h0;
      tx_stuff_r <= 1'b0;
    end else if (full_tick) begin
      if (tx_load) begin
        tx_state_r <= TX_SHIFT;
        tx_sh_r <= tbuf_r;
        tx_left_r <= tx_cfg_r;
        tx_level_r <= tbuf_r[0] ? tx_level_r : ~tx_level_r;
        tx_ones_r <= tbuf_r[0] ? 3'h1 : 3'h0;
        tx_stuff_r <= 1'b0;
      end else begin
        unique case (tx_state_r)
          TX_IDLE: ;
          TX_SHIFT: begin
            if (stuff_now) begin
              tx_level_r <= ~tx_level_r;
              tx_ones_r <= 3'h0;
              tx_stuff_r <= 1'b1;
            end else if (tx_done) begin
              tx_stuff_r <= 1'b0;
              if (is_diff(code)) begin
                tx_state_r <= TX_EOP;
                eop_cnt_r <= EOP_BITS;
              end else begin
                tx_state_r <= TX_IDLE;
              end
            end else begin
              tx_stuff_r <= 1'b0;
              tx_sh_r <= {1'b0, tx_sh_r[15:1]};
              tx_left_r <= tx_left_r - 5'h01;
              tx_level_r <= tx_sh_r[1] ? tx_level_r : ~tx_level_r;
              tx_ones_r <= tx_sh_r[1] ? tx_ones_r + 3'h1 : 3'h0;
            end
          end
          TX_EOP: begin
            eop_cnt_r <= eop_cnt_r - 2'h1;
            if (eop_cnt_r == 2'h1) begin
              tx_state_r <= TX_IDLE;
            end
          end
          default: tx_state_r <= TX_IDLE;
        endcase
      end
    end
  end

  // line value per protocol; idle and eop both hold the pins low
  logic line_bit;
  logic plus_nxt;
  logic minus_nxt;
  logic [PE_CYCLES-1:0] pe_plus_r;
  logic [PE_CYCLES-1:0] pe_minus_r;

  always_comb begin
    if (code == PROTO_ETH) begin
      line_bit = phase_r ? tx_sh_r[0] : ~tx_sh_r[0];
    end else if (code == PROTO_USB) begin
      line_bit = tx_level_r;
    end else begin
      line_bit = tx_sh_r[0];
    end
    plus_nxt = 1'b0;
    minus_nxt = 1'b0;
    if (tx_state_r == TX_SHIFT) begin
      plus_nxt = line_bit;
      minus_nxt = is_diff(code) & ~line_bit;
    end
  end

  // pin drivers and the pre-emphasis delay line
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_plus_pin_out <= 1'b0;
      tx_minus_pin_out <= 1'b0;
      pe_plus_r <= '0;
      pe_minus_r <= '0;
      tx_plus_delayed_pin_out <= 1'b0;
      tx_minus_delayed_pin_out <= 1'b0;
    end else begin
      tx_plus_pin_out <= plus_nxt;
      tx_minus_pin_out <= minus_nxt;
      pe_plus_r <= {pe_plus_r[PE_CYCLES-2:0], plus_nxt};
      pe_minus_r <= {pe_minus_r[PE_CYCLES-2:0], minus_nxt};
      tx_plus_delayed_pin_out <= (code == PROTO_ETH) & pe_plus_r[PE_CYCLES-1];
      tx_minus_delayed_pin_out <= (code == PROTO_ETH) & pe_minus_r[PE_CYCLES-1];
    end
  end

  // receiver
  rx_state_t rx_state_r;
  logic [15:0] rx_sh_r;
  logic [CNT_W-1:0] rx_left_r;
  logic [CNT_W-1:0] rx_bits_r;
  logic [7:0] win_r;
  logic rx_prev_r;
  logic [2:0] rx_ones_r;
  logic uses_sync;
  logic rx_bit;
  logic rx_skip;
  logic [7:0] pattern;
  logic rx_take;
  logic rx_word_done;
  logic rx_eop_hit;
  logic eop_line;

  assign uses_sync = is_diff(code);
  assign pattern = (code == PROTO_ETH) ? SFD_ETH : sync_r;
  assign rx_bit = (code == PROTO_USB) ? (rx_data_pin_in == rx_prev_r) : rx_data_pin_in;
  assign rx_skip = (code == PROTO_USB) && (rx_ones_r == STUFF_ONES);
  assign rx_take = full_tick && !rx_skip && (rx_state_r == RX_DATA);
  assign eop_line = (code == PROTO_GPSI) ? ~rx_plus_pin_in : (~rx_plus_pin_in & ~rx_minus_pin_in);
  assign rx_eop_hit = rx_eop_mode(code) && (rx_state_r == RX_DATA) &&
                      (rx_bits_r != 5'h00) && eop_line;
  assign rx_word_done = rx_take && !rx_eop_hit && (rx_left_r <= 5'h01);

  // in eth and usb a pattern match opens the data phase; matching stays off until eop
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_state_r <= RX_OFF;
      rx_sh_r <= 16'h0000;
      rx_left_r <= '0;
      rx_bits_r <= '0;
      win_r <= 8'h00;
      rx_prev_r <= 1'b0;
      rx_ones_r <= 3'h0;
      rbuf_r <= 16'h0000;
      rx_rcvd_r <= '0;
    end else if (rx_setup) begin
      rx_state_r <= uses_sync ? RX_HUNT : RX_DATA;
      rx_left_r <= wr_merged[CNT_W-1:0];
      rx_bits_r <= '0;
      win_r <= 8'h00;
    end else if (rx_eop_hit) begin
      rx_rcvd_r <= rx_bits_r;
      rbuf_r <= rx_sh_r;
      rx_bits_r <= '0;
      rx_left_r <= rx_cfg_r;
      rx_state_r <= uses_sync ? RX_HUNT : RX_DATA;
      win_r <= 8'h00;
    end else if (full_tick) begin
      rx_prev_r <= rx_data_pin_in;
      rx_ones_r <= (rx_skip || !rx_bit) ? 3'h0 : rx_ones_r + 3'h1;
      if (!rx_skip) begin
        unique case (rx_state_r)
          RX_OFF: ;
          RX_HUNT: begin
            win_r <= {win_r[6:0], rx_bit};
            if ({win_r[6:0], rx_bit} == pattern) begin
              rx_state_r <= RX_DATA;
              rx_bits_r <= '0;
              rx_left_r <= rx_cfg_r;
            end
          end
          RX_DATA: begin
            rx_sh_r <= {rx_sh_r[14:0], rx_bit};
            if (rx_word_done) begin
              rbuf_r <= {rx_sh_r[14:0], rx_bit};
              rx_left_r <= rx_cfg_r;
              rx_bits_r <= '0;
            end else begin
              rx_left_r <= rx_left_r - 5'h01;
              rx_bits_r <= rx_bits_r + 5'h01;
            end
          end
          default: rx_state_r <= RX_OFF;
        endcase
      end
    end
  end

  // sticky flags: hardware set wins over a write-one-to-clear in the same cycle
  always_comb begin
    flag_nxt = flag_r;
    if (wr_acc && (avs_address_in == OFS_IRQ_FLAG)) begin
      flag_nxt = flag_r & ~wr_word[FLAG_W-1:0];
    end
    if (rx_word_done || rx_eop_hit) begin
      flag_nxt[FLAG_RX_FULL] = 1'b1;
    end
    if (rx_eop_hit) begin
      flag_nxt[FLAG_RX_EOP] = 1'b1;
    end
    if (tx_load) begin
      flag_nxt[FLAG_TX_EMPTY] = 1'b1;
    end
    if (tx_underrun) begin
      flag_nxt[FLAG_TX_UNDERRUN] = 1'b1;
    end
  end

  // flags and the unit interrupt request
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flag_r <= '0;
      irq_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_r <= |(flag_r & ien_r);
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign irq_out = irq_r;
endmodule // multiprotocol_serdes
`default_nettype wire

/* File: multiprotocol_serdes_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module serdes_checker
  import serdes_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] avs_address_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic tx_plus_pin_out,
  input wire logic tx_minus_pin_out,
  input wire logic tx_plus_delayed_pin_out,
  input wire logic tx_minus_delayed_pin_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic acc_w;
  logic [3:0] mode_r;
  logic [3:0] en_r;
  logic [3:0] age_r;
  logic armed_r;
  // a write lands at the edge where waitrequest is low
  assign acc_w = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  // shadow copies of mode and enables, taken at the same edge as the slave
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_r <= 4'h0;
      en_r <= 4'h0;
    end else if (acc_w && avs_address_in == OFS_MODE) begin
      mode_r <= avs_writedata_in[3:0];
    end else if (acc_w && avs_address_in == OFS_IRQ_EN) begin
      en_r <= avs_writedata_in[3:0];
    end
  end
  // cycles since a mode write; saturates late so the delay line has drained
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      age_r <= 4'h0;
    end else if (acc_w && avs_address_in == OFS_MODE) begin
      age_r <= 4'h0;
    end else if (age_r != 4'hF) begin
      age_r <= age_r + 4'h1;
    end
  end
  // until software first writes a buffer byte nothing may leave the pins
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      armed_r <= 1'h0;
    end else if (acc_w && (avs_address_in == OFS_TX_BUF_LO ||
                           avs_address_in == OFS_TX_BUF_HI)) begin
      armed_r <= 1'h1;
    end
  end
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  AST_BUS_ACK: assert property (s_req |=> s_ack)
    else $error("bus access not answered in one cycle");
  AST_ACK_CAUSE: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
    else $error("waitrequest low without a request");
  AST_RD_ZERO: assert property (avs_read_in && !avs_waitrequest_out &&
    (avs_address_in == OFS_TX_BUF_LO || avs_address_in == OFS_TX_BUF_HI ||
    avs_address_in > OFS_CLK_DIV) |-> avs_readdata_out == 32'h0)
    else $error("write-only or unmapped place read non-zero");
  AST_MINUS_SE: assert property (!is_diff(mode_r) && age_r > 4'h1 |-> !tx_minus_pin_out)
    else $error("minus pin driven in a single-ended mode");
  AST_PE_OFF: assert property (mode_r != PROTO_ETH && age_r == 4'hF |->
    !tx_plus_delayed_pin_out && !tx_minus_delayed_pin_out)
    else $error("delayed outputs active outside 10base-t");
  AST_PE_COPY: assert property (mode_r == PROTO_ETH && age_r == 4'hF |->
    tx_plus_delayed_pin_out == $past(tx_plus_pin_out, 13) &&
    tx_minus_delayed_pin_out == $past(tx_minus_pin_out, 13))
    else $error("delayed outputs not a 13 cycle copy");
  AST_IRQ_MASK: assert property (en_r == 4'h0 && $past(en_r) == 4'h0 |-> !irq_out)
    else $error("irq raised with all enables clear");
  AST_IDLE_LOW: assert property (!armed_r |-> !tx_plus_pin_out && !tx_minus_pin_out)
    else $error("tx pins active before any transmission");
endmodule // serdes_checker
`default_nettype wire

/* File: serdes_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serdes_line_model (
  input wire logic clk_in,
  output logic sclk_out,
  output logic data_out,
  output logic valid_out
);
  // idle line: clock stands still, valid low
  initial begin
    sclk_out = 1'h0;
    data_out = 1'h0;
    valid_out = 1'h0;
  end
  // one frame, highest bit first; clock runs only inside the frame
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk_in);
      data_out <= bits[i];
      valid_out <= 1'h1;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'h1;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'h0;
    end
    @(posedge clk_in);
    valid_out <= 1'h0;
    data_out <= ~bits[0]; // released line must not look held
  endtask
endmodule // serdes_line_model
`default_nettype wire

/* File: tb_multiprotocol_serdes.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_multiprotocol_serdes;
  import serdes_pkg::*;
  logic clk_in;
  logic rstn_in;
  logic [7:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  wire logic [31:0] avs_readdata_out;
  wire logic avs_waitrequest_out;
  wire logic line_clk;
  wire logic line_data;
  wire logic line_valid;
  wire logic tx_p;
  wire logic tx_m;
  wire logic tx_pd;
  wire logic tx_md;
  wire logic irq_out;
  int n_errors;
  int checks_done;
  int n;
  logic [31:0] q;
  logic [7:0] vec;
  logic saw_m;
  logic saw_pe;

  // the core clock never stops while the unit transmits
  initial clk_in = 1'h0;
  always #2 clk_in = ~clk_in;

  multiprotocol_serdes multiprotocol_serdes_inst (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .avs_address_in(avs_address_in),
    .avs_byteenable_in(4'hF),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .serial_clock_pin_in(line_clk),
    .rx_plus_pin_in(line_valid),
    .rx_minus_pin_in(1'h0),
    .rx_data_pin_in(line_data),
    .tx_plus_pin_out(tx_p),
    .tx_minus_pin_out(tx_m),
    .tx_plus_delayed_pin_out(tx_pd),
    .tx_minus_delayed_pin_out(tx_md),
    .irq_out(irq_out)
  );

  // only serial_clock_pin_in, rx_plus_pin_in and rx_data_pin_in are wired to the far side; rx_minus_pin_in is tied low
  serdes_line_model serdes_line_model_inst (
    .clk_in(clk_in),
    .sclk_out(line_clk),
    .data_out(line_data),
    .valid_out(line_valid)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access; the edge after release is left free before the next one
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'h0 && k < 50) begin
      k++;
      @(posedge clk_in);
    end
    if (k >= 50) begin
      n_errors++;
      $display("ERROR bus expected answer seen none");
    end
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string w);
    xfer(1'h0, a, 32'h0);
    check(w, q & m, e);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    $display("ERROR watchdog expected finish seen hang");
    results();
  end

  initial begin
    rstn_in = 1'h0;
    avs_address_in = 8'h00;
    avs_read_in = 1'h0;
    avs_write_in = 1'h0;
    avs_writedata_in = 32'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'h1;
    // reset values and refused places
    rd(OFS_RX_SHIFT, 32'h1F, 32'h10, "rx shift count");
    rd(OFS_TX_COUNT, 32'h1F, 32'h10, "tx count");
    rd(OFS_CLK_DIV, 32'hFFFF, 32'h7, "divider");
    rd(OFS_MODE, 32'h1F, 32'h0, "mode");
    rd(OFS_IRQ_FLAG, 32'hF, 32'h0, "flags");
    wr(8'h2C, 32'hFFFFFFFF);
    rd(8'h2C, 32'hFFFFFFFF, 32'h0, "unmapped");
    rd(OFS_TX_BUF_LO, 32'hFFFFFFFF, 32'h0, "tx buffer read");
    $display("test reset done");
    // uart: low byte alone must not start; then 4 bits, lsb first, 2 cycles each
    wr(OFS_CLK_DIV, 32'h0);
    wr(OFS_MODE, {28'h0, PROTO_UART});
    wr(OFS_TX_COUNT, 32'h4);
    wr(OFS_IRQ_EN, 32'h6);
    wr(OFS_TX_BUF_LO, 32'h05);
    repeat (20) @(posedge clk_in);
    rd(OFS_IRQ_FLAG, 32'h6, 32'h0, "flags before high byte");
    wr(OFS_TX_BUF_HI, 32'h0);
    n = 0;
    while (tx_p !== 1'h1 && n < 200) begin
      n++;
      @(posedge clk_in);
    end
    repeat (8) begin
      vec = {vec[6:0], tx_p};
      @(posedge clk_in);
    end
    check("uart bits", {24'h0, vec}, 32'hCC);
    repeat (20) @(posedge clk_in);
    rd(OFS_IRQ_FLAG, 32'h6, 32'h6, "tx flags");
    check("irq set", {31'h0, irq_out}, 32'h1);
    wr(OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk_in);
    check("irq masked", {31'h0, irq_out}, 32'h0);
    wr(OFS_IRQ_FLAG, 32'hF);
    rd(OFS_IRQ_FLAG, 32'h6, 32'h0, "flags cleared");
    $display("test uart done");
    // 10base-t: differential pair, delayed copies, underrun end of packet
    wr(OFS_MODE, {28'h0, PROTO_ETH});
    wr(OFS_TX_COUNT, 32'h2);
    wr(OFS_TX_BUF_LO, 32'h01);
    wr(OFS_TX_BUF_HI, 32'h0);
    saw_m = 1'h0;
    saw_pe = 1'h0;
    repeat (80) begin
      @(posedge clk_in);
      saw_m = saw_m | tx_m;
      saw_pe = saw_pe | tx_pd;
    end
    check("minus driven", {31'h0, saw_m}, 32'h1);
    check("delayed driven", {31'h0, saw_pe}, 32'h1);
    check("pins idle", {28'h0, tx_p, tx_m, tx_pd, tx_md}, 32'h0);
    rd(OFS_IRQ_FLAG, 32'h6, 32'h6, "underrun flags");
    $display("test eth done");
    // gpsi: frame of 5 bits cut short by end of packet
    wr(OFS_MODE, {28'h0, PROTO_GPSI});
    wr(OFS_RX_SHIFT, 32'h10);
    wr(OFS_IRQ_FLAG, 32'hF);
    serdes_line_model_inst.send(16'h0016, 5);
    repeat (20) @(posedge clk_in);
    rd(OFS_RX_RCVD, 32'h1F, 32'h5, "received count");
    rd(OFS_IRQ_FLAG, 32'hF, 32'h9, "eop flags");
    rd(OFS_RX_BUF, 32'h1F, 32'h16, "eop data");
    $display("test gpsi done");
    // spi: sync pattern must play no part, count of 8 fills the buffer
    wr(OFS_SYNC, 32'hFF);
    wr(OFS_MODE, {28'h0, PROTO_SPI});
    wr(OFS_RX_SHIFT, 32'h8);
    wr(OFS_IRQ_FLAG, 32'hF);
    serdes_line_model_inst.send(16'h00A5, 8);
    repeat (20) @(posedge clk_in);
    rd(OFS_RX_BUF, 32'hFF, 32'hA5, "spi data");
    rd(OFS_IRQ_FLAG, 32'hF, 32'h1, "spi flags");
    $display("test spi done");
    results();
  end
endmodule // tb_multiprotocol_serdes

bind multiprotocol_serdes serdes_checker serdes_checker_inst (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .avs_address_in(avs_address_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .tx_plus_pin_out(tx_plus_pin_out),
  .tx_minus_pin_out(tx_minus_pin_out),
  .tx_plus_delayed_pin_out(tx_plus_delayed_pin_out),
  .tx_minus_delayed_pin_out(tx_minus_delayed_pin_out),
  .irq_out(irq_out)
);
`default_nettype wire
